// file: inc/adc_scan_pkg.sv
// Purpose: Types shared by the scan event slice and its decoder.
// Assumes: adc_scan_regs.svh is on the include path.
// Notes:   Scan modes are plain codes; the tracker state is one-hot.
package adc_scan_pkg;
`include "adc_scan_regs.svh"

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_CONT   = 2'h1,
      MODE_GROUP  = 2'h2
   } scan_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SCAN = 2'b10
   } scan_state_t;

   typedef struct packed {
      logic                   valid;
      logic [`ADC_CHAN_W-1:0] chan;
      logic [`ADC_DATA_W-1:0] data;
      logic                   last;
      logic                   group_b;
   } result_wr_t;

   typedef struct packed {
      logic                   legal;
      logic [`ADC_CHAN_W-1:0] chan;
   } win_b_sel_t;

   typedef struct packed {
      logic scan_any;
      logic scan_not_b;
      logic scan_b;
      logic window;
   } elc_event_t;

endpackage : adc_scan_pkg

// file: inc/adc_scan_regs.svh
// Purpose: Named widths, channel codes and reset values for the scan slice.
// Assumes: Included by the package and by every design file.
// Notes:   Definitions only.
`ifndef ADC_SCAN_REGS_SVH
`define ADC_SCAN_REGS_SVH

`define ADC_CHAN_W      6
`define ADC_DATA_W      12
`define ADC_MASK_W      32
`define ADC_RES_NUM     25
`define ADC_RES_IDX_W   5
`define ADC_SAMP_NUM    12
`define ADC_SAMP_IDX_W  4
`define ADC_SAMP_W      8
`define ADC_SAMP_RST    8'h0D
`define ADC_CH_LO_LAST  6'h08
`define ADC_CH8         6'h08
`define ADC_CH_HI_BASE  6'h10
`define ADC_CH_HI_LAST  6'h1F
`define ADC_CH_TEMP     6'h20
`define ADC_CH_IREF     6'h21
`define ADC_HI_IDX_OFS  6'h07
`define ADC_CH8_BIT     8
`define ADC_VALID_MASK  32'hFFFF_00FF
`define ADC_MASK_RST    32'h0000_0000
`define ADC_DATA_RST    12'h000

`endif

// file: rtl/adc_scan_event_ctrl.sv
// Purpose: Event link outputs, scan start, window compare and per-channel
//          result and sampling storage of the converter's digital slice.
// Assumes: Result writes and triggers arrive on sys_clk from on-chip logic.
// Notes:   Module stop blocks result writes and triggers; the analog clock enable drops.
`timescale 1ns/1ps
`include "adc_scan_regs.svh"

module adc_scan_event_ctrl
   import adc_scan_pkg::*;
(
   input  wire logic                      sys_clk,
   input  wire logic                      srst,
   input  wire logic                      module_stop,
   input  scan_mode_t                     scan_mode,
   input  wire logic                      elc_trig_enable,
   input  wire logic                      event_link_controller_trig,
   input  result_wr_t                     res_in,
   input  wire logic [`ADC_MASK_W-1:0]    group_a_select,
   input  wire logic                      group_a_chan8_select,
   input  wire logic [`ADC_MASK_W-1:0]    group_b_select,
   input  wire logic                      group_b_chan8_select,
   input  wire logic [`ADC_MASK_W-1:0]    add_avg_select,
   input  wire logic                      chan8_add_avg_select,
   input  wire logic                      window_a_chan8_enable,
   input  wire logic                      window_a_chan8_condition,
   input  wire logic                      window_a_flag_clr,
   input  wire logic [`ADC_DATA_W-1:0]    window_a_level,
   input  wire logic [`ADC_CHAN_W-1:0]    window_b_channel_select,
   input  wire logic                      window_b_enable,
   input  wire logic                      window_b_condition,
   input  wire logic                      window_b_flag_clr,
   input  wire logic [`ADC_DATA_W-1:0]    window_b_level,
   input  wire logic                      dac_sync_mode,
   input  wire logic [`ADC_CHAN_W-1:0]    rd_chan,
   input  wire logic                      samp_wr,
   input  wire logic [`ADC_SAMP_IDX_W-1:0] samp_idx,
   input  wire logic [`ADC_SAMP_W-1:0]    samp_data,
   input  wire logic [`ADC_SAMP_IDX_W-1:0] samp_rd_idx,
   output logic                           analog_clk_enable,
   output logic                           scan_start_ff,
   output logic [`ADC_MASK_W-1:0]         scan_chan_mask_ff,
   output logic [`ADC_MASK_W-1:0]         add_avg_mask_ff,
   output elc_event_t                     elc_event_ff,
   output logic                           scan_end_irq_ff,
   output logic                           group_b_scan_end_irq_ff,
   output logic                           window_a_chan8_flag_ff,
   output logic                           window_b_flag_ff,
   output logic                           dac_adc_sync_enable_ff,
   output logic [`ADC_DATA_W-1:0]         rd_data_ff,
   output logic [`ADC_SAMP_W-1:0]         samp_count_ff
);

   // Stopped module ignores result writes and triggers; clock gating is modelled
   // by dropping the analog clock enable; sampling writes, reads and flag clears still act.
   logic       run;
   logic       wr_ok;
   logic       trig_ok;
   win_b_sel_t win_b;

   assign run               = !module_stop;
   assign analog_clk_enable = run;
   assign wr_ok             = run && res_in.valid;
   assign trig_ok           = run && elc_trig_enable
                              && event_link_controller_trig;

   window_b_decode u_win_b (
      .sys_clk                 (sys_clk),
      .srst                    (srst),
      .window_b_channel_select (window_b_channel_select),
      .sel_ff                  (win_b)
   );

   // Scan tracker, start pulse and latched channel masks.
   scan_state_t             state_ff;
   scan_state_t             nxt_state;
   logic                    nxt_start;
   logic [`ADC_MASK_W-1:0]  sel_a;
   logic [`ADC_MASK_W-1:0]  sel_b;
   logic [`ADC_MASK_W-1:0]  sel_avg;
   logic [`ADC_MASK_W-1:0]  nxt_mask;
   logic [`ADC_MASK_W-1:0]  nxt_avg;

   always_comb begin
      sel_a   = group_a_select & `ADC_VALID_MASK;
      sel_b   = group_b_select & `ADC_VALID_MASK;
      sel_avg = add_avg_select & `ADC_VALID_MASK;
      sel_a[`ADC_CH8_BIT]   = group_a_chan8_select;
      sel_b[`ADC_CH8_BIT]   = group_b_chan8_select;
      sel_avg[`ADC_CH8_BIT] = chan8_add_avg_select;
      nxt_state = state_ff;
      nxt_start = 1'b0;
      nxt_mask  = scan_chan_mask_ff;
      nxt_avg   = add_avg_mask_ff;
      case (state_ff)
         ST_IDLE: begin
            if (trig_ok) begin
               nxt_state = ST_SCAN;
               nxt_start = 1'b1;
               nxt_mask  = sel_a;
               nxt_avg   = sel_avg;
            end else if (wr_ok && res_in.group_b) begin
               nxt_mask  = sel_b;
            end
         end
         ST_SCAN: begin
            if (wr_ok && res_in.last && !res_in.group_b) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_ff          <= ST_IDLE;
         scan_start_ff     <= 1'b0;
         scan_chan_mask_ff <= `ADC_MASK_RST;
         add_avg_mask_ff   <= `ADC_MASK_RST;
      end else begin
         state_ff          <= nxt_state;
         scan_start_ff     <= nxt_start;
         scan_chan_mask_ff <= nxt_mask;
         add_avg_mask_ff   <= nxt_avg;
      end
   end

   // Window compare: channel 8 on window A, selected channel on window B.
   logic match_a;
   logic match_b;
   logic nxt_flag_a;
   logic nxt_flag_b;

   always_comb begin
      match_a = wr_ok && window_a_chan8_enable
         && (res_in.chan == `ADC_CH8)
         && (window_a_chan8_condition ? (res_in.data > window_a_level)
                                      : (res_in.data < window_a_level));
      match_b = wr_ok && window_b_enable && win_b.legal
         && (res_in.chan == win_b.chan)
         && (window_b_condition ? (res_in.data > window_b_level)
                                : (res_in.data < window_b_level));
      // A match in the same cycle as a clear keeps the flag set.
      nxt_flag_a = match_a || (window_a_chan8_flag_ff && !window_a_flag_clr);
      nxt_flag_b = match_b || (window_b_flag_ff && !window_b_flag_clr);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         window_a_chan8_flag_ff <= 1'b0;
         window_b_flag_ff       <= 1'b0;
      end else begin
         window_a_chan8_flag_ff <= nxt_flag_a;
         window_b_flag_ff       <= nxt_flag_b;
      end
   end

   // Event link pulses, interrupts and the D/A update enable.
   elc_event_t nxt_evt;
   logic       scan_done;
   logic       group_mode;
   logic       nxt_irq_a;
   logic       nxt_irq_b;
   logic       nxt_dac_en;

   always_comb begin
      scan_done  = wr_ok && res_in.last;
      group_mode = (scan_mode == MODE_GROUP);
      nxt_evt.scan_any   = scan_done;
      nxt_evt.scan_not_b = scan_done && group_mode
                           && !res_in.group_b;
      nxt_evt.scan_b     = scan_done && group_mode
                           && res_in.group_b;
      nxt_evt.window     = (scan_mode == MODE_SINGLE)
                           && (match_a || match_b);
      nxt_irq_a = scan_done && !(group_mode && res_in.group_b);
      nxt_irq_b = scan_done && group_mode && res_in.group_b;
      // D/A may update only while no scan runs, when sync mode is on.
      nxt_dac_en = !dac_sync_mode
                   || ((nxt_state == ST_IDLE) && !res_in.valid);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         elc_event_ff            <= '0;
         scan_end_irq_ff         <= 1'b0;
         group_b_scan_end_irq_ff <= 1'b0;
         dac_adc_sync_enable_ff  <= 1'b1;
      end else begin
         elc_event_ff            <= nxt_evt;
         scan_end_irq_ff         <= nxt_irq_a;
         group_b_scan_end_irq_ff <= nxt_irq_b;
         dac_adc_sync_enable_ff  <= nxt_dac_en;
      end
   end

   // Result storage: entries 0-8 hold channels 0-8, 9-24 hold 16-31.
   logic [`ADC_DATA_W-1:0]    res_mem_ff [`ADC_RES_NUM];
   logic [`ADC_RES_IDX_W-1:0] wr_idx;
   logic                      wr_map;
   logic [`ADC_RES_IDX_W-1:0] rd_idx;
   logic                      rd_map;
   logic [`ADC_CHAN_W-1:0]    wr_tmp;
   logic [`ADC_CHAN_W-1:0]    rd_tmp;
   logic [`ADC_DATA_W-1:0]    nxt_rd;

   always_comb begin
      wr_tmp = (res_in.chan <= `ADC_CH_LO_LAST) ? res_in.chan
                                                : res_in.chan - `ADC_HI_IDX_OFS;
      rd_tmp = (rd_chan <= `ADC_CH_LO_LAST) ? rd_chan
                                            : rd_chan - `ADC_HI_IDX_OFS;
      wr_idx = wr_tmp[`ADC_RES_IDX_W-1:0];
      rd_idx = rd_tmp[`ADC_RES_IDX_W-1:0];
      wr_map = wr_ok && ((res_in.chan <= `ADC_CH_LO_LAST)
               || ((res_in.chan >= `ADC_CH_HI_BASE)
                   && (res_in.chan <= `ADC_CH_HI_LAST)));
      rd_map = (rd_chan <= `ADC_CH_LO_LAST)
               || ((rd_chan >= `ADC_CH_HI_BASE)
                   && (rd_chan <= `ADC_CH_HI_LAST));
      nxt_rd = rd_map ? res_mem_ff[rd_idx] : `ADC_DATA_RST;
   end

   // Sampling counts: entries 0-8 per channel, then L, T and O sources.
   logic [`ADC_SAMP_W-1:0] samp_ff [`ADC_SAMP_NUM];
   logic [`ADC_SAMP_W-1:0] nxt_samp_rd;

   always_comb begin
      nxt_samp_rd = (samp_rd_idx < `ADC_SAMP_IDX_W'(`ADC_SAMP_NUM))
                    ? samp_ff[samp_rd_idx] : `ADC_SAMP_RST;
   end

   genvar gi;
   generate
      for (gi = 0; gi < `ADC_RES_NUM; gi++) begin : g_res
         logic [`ADC_DATA_W-1:0] nxt_val;
         always_comb begin
            nxt_val = (wr_map && (wr_idx == `ADC_RES_IDX_W'(gi)))
                      ? res_in.data : res_mem_ff[gi];
         end
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               res_mem_ff[gi] <= `ADC_DATA_RST;
            end else begin
               res_mem_ff[gi] <= nxt_val;
            end
         end
      end
      for (gi = 0; gi < `ADC_SAMP_NUM; gi++) begin : g_samp
         logic [`ADC_SAMP_W-1:0] nxt_val;
         always_comb begin
            nxt_val = (samp_wr && (samp_idx == `ADC_SAMP_IDX_W'(gi)))
                      ? samp_data : samp_ff[gi];
         end
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               samp_ff[gi] <= `ADC_SAMP_RST;
            end else begin
               samp_ff[gi] <= nxt_val;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_data_ff    <= `ADC_DATA_RST;
         samp_count_ff <= `ADC_SAMP_RST;
      end else begin
         rd_data_ff    <= nxt_rd;
         samp_count_ff <= nxt_samp_rd;
      end
   end

   default clocking dcb @(posedge sys_clk); endclocking
   default disable iff (srst);

   any_end_a: assert property (
      (run && res_in.valid && res_in.last) |=> elc_event_ff.scan_any)
      else $error("Scan end event missing.");
   not_b_a: assert property (
      (wr_ok && res_in.last && group_mode && !res_in.group_b)
      |=> (elc_event_ff.scan_not_b && !elc_event_ff.scan_b))
      else $error("Non-B scan end event wrong.");
   b_end_a: assert property (
      elc_event_ff.scan_b |-> $past(res_in.group_b) && !elc_event_ff.scan_not_b)
      else $error("Group B scan end event wrong.");
   start_pulse_a: assert property (
      (trig_ok && state_ff == ST_IDLE) |=> scan_start_ff ##1 !scan_start_ff)
      else $error("Trigger did not start one scan.");
   win_event_a: assert property (
      elc_event_ff.window |-> ($past(scan_mode) == MODE_SINGLE))
      else $error("Window event outside single scan mode.");
   stop_quiet_a: assert property (
      module_stop [*2] |-> !elc_event_ff.scan_any && !scan_start_ff)
      else $error("Activity while module stopped.");
   flag_set_a: assert property (
      match_a |=> window_a_chan8_flag_ff)
      else $error("Window A flag not set or lost to clear.");
   irq_b_a: assert property (
      group_b_scan_end_irq_ff |-> !scan_end_irq_ff && elc_event_ff.scan_b)
      else $error("Group B interrupt mismatched.");
   dac_hold_a: assert property (
      (dac_sync_mode && state_ff == ST_SCAN && $past(dac_sync_mode))
      |-> !dac_adc_sync_enable_ff)
      else $error("D/A enabled during a scan.");
   pulse_one_a: assert property (
      elc_event_ff.scan_any |-> $past(scan_done))
      else $error("Event not one cycle after the write.");

endmodule : adc_scan_event_ctrl

// file: rtl/window_b_decode.sv
// Purpose: Registers and checks the window B channel selector code.
// Assumes: Selector comes from logic on sys_clk.
// Notes:   Prohibited codes leave legal low so window B never matches.
`timescale 1ns/1ps
`include "adc_scan_regs.svh"
module window_b_decode
   import adc_scan_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   input  wire logic [`ADC_CHAN_W-1:0] window_b_channel_select,
   output win_b_sel_t                  sel_ff
);
   win_b_sel_t nxt_sel;

   always_comb begin
      nxt_sel.chan  = window_b_channel_select;
      nxt_sel.legal = (window_b_channel_select <= `ADC_CH_LO_LAST)
         || ((window_b_channel_select >= `ADC_CH_HI_BASE)
             && (window_b_channel_select <= `ADC_CH_HI_LAST))
         || (window_b_channel_select == `ADC_CH_TEMP)
         || (window_b_channel_select == `ADC_CH_IREF);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sel_ff <= '0;
      end else begin
         sel_ff <= nxt_sel;
      end
   end

   default clocking dcb @(posedge sys_clk); endclocking
   default disable iff (srst);

   b_prohibit_a: assert property (
      ((window_b_channel_select > `ADC_CH_LO_LAST)
       && (window_b_channel_select < `ADC_CH_HI_BASE)) |=> !sel_ff.legal)
      else $error("Prohibited window B code decoded as legal.");

endmodule : window_b_decode

// file: verif/adc_scan_event_compare_select_tb.sv
// Purpose: Self-checking bench for the scan event slice.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes:   Outputs are sampled 1 ns after the edge that updates them.
`timescale 1ns/1ps
`include "adc_scan_regs.svh"
module adc_scan_event_compare_select_tb;
   import adc_scan_pkg::*;
   logic sys_clk, srst, module_stop, elc_trig_enable, fire, dac_wr;
   logic event_link_controller_trig, group_a_chan8_select;
   logic group_b_chan8_select, chan8_add_avg_select, window_a_chan8_enable;
   logic window_a_chan8_condition, window_a_flag_clr, window_b_enable;
   logic window_b_condition, window_b_flag_clr, dac_sync_mode, samp_wr;
   logic analog_clk_enable, scan_start_ff, scan_end_irq_ff;
   logic group_b_scan_end_irq_ff, window_a_chan8_flag_ff, window_b_flag_ff;
   logic dac_adc_sync_enable_ff;
   scan_mode_t scan_mode;
   result_wr_t res_in;
   elc_event_t elc_event_ff;
   logic [31:0] group_a_select, group_b_select, add_avg_select;
   logic [31:0] scan_chan_mask_ff, add_avg_mask_ff;
   logic [11:0] window_a_level, window_b_level, rd_data_ff;
   logic [5:0]  window_b_channel_select, rd_chan;
   logic [3:0]  samp_idx, samp_rd_idx;
   logic [7:0]  samp_data, samp_count_ff, dac_code, dac_out, ev_cnt;
   int          bad_count, check_count, n;
   logic [5:0]  wb_code [10] = '{6'h00, 6'h08, 6'h10, 6'h1F, 6'h20,
                                 6'h21, 6'h09, 6'h0F, 6'h22, 6'h3F};

   adc_scan_event_ctrl dut (.sys_clk, .srst, .module_stop, .scan_mode,
      .elc_trig_enable, .event_link_controller_trig, .res_in,
      .group_a_select, .group_a_chan8_select, .group_b_select,
      .group_b_chan8_select, .add_avg_select, .chan8_add_avg_select,
      .window_a_chan8_enable, .window_a_chan8_condition,
      .window_a_flag_clr, .window_a_level, .window_b_channel_select,
      .window_b_enable, .window_b_condition, .window_b_flag_clr,
      .window_b_level, .dac_sync_mode, .rd_chan, .samp_wr, .samp_idx,
      .samp_data, .samp_rd_idx, .analog_clk_enable, .scan_start_ff,
      .scan_chan_mask_ff, .add_avg_mask_ff, .elc_event_ff,
      .scan_end_irq_ff, .group_b_scan_end_irq_ff,
      .window_a_chan8_flag_ff, .window_b_flag_ff,
      .dac_adc_sync_enable_ff, .rd_data_ff, .samp_count_ff);

   elc_dac_model partner (.sys_clk, .srst, .fire, .events(elc_event_ff),
      .sync_en(dac_adc_sync_enable_ff), .sync_mode(dac_sync_mode),
      .dac_wr, .dac_code, .trig_ff(event_link_controller_trig),
      .dac_out_ff(dac_out), .event_cnt_ff(ev_cnt));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic print_verdict;
      if (bad_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, exp, input string msg);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %0h exp %0h", $time, msg,
                  got, exp);
      end
   endtask : chk

   task automatic chk_ev(input logic [5:0] exp);
      chk({26'h0, elc_event_ff, scan_end_irq_ff, group_b_scan_end_irq_ff},
          {26'h0, exp}, "events");
   endtask : chk_ev

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic wr_res(input logic [5:0] ch, input logic [11:0] d,
                         input logic l, b);
      @(posedge sys_clk) res_in <= '{1'b1, ch, d, l, b};
      @(posedge sys_clk) res_in <= '0;
      #1;
   endtask : wr_res

   // Pulses the model's request and counts start pulses in a fixed window.
   task automatic trig(input int exp);
      @(posedge sys_clk) fire <= 1'b1;
      @(posedge sys_clk) fire <= 1'b0;
      n = 0;
      repeat (4) begin
         tick(1);
         n += int'(scan_start_ff === 1'b1);
      end
      chk(n, exp, "start pulses");
   endtask : trig

   task automatic rd(input logic [5:0] ch, input logic [11:0] exp);
      @(posedge sys_clk) rd_chan <= ch;
      tick(2);
      chk(rd_data_ff, exp, "result");
   endtask : rd

   task automatic samp(input logic w, input logic [3:0] i,
                       input logic [7:0] d);
      @(posedge sys_clk) begin
         samp_wr <= w;
         samp_idx <= i;
         samp_data <= d;
         samp_rd_idx <= i;
      end
      @(posedge sys_clk) samp_wr <= 1'b0;
      tick(2);
      chk(samp_count_ff, d, "sampling count");
   endtask : samp

   task automatic pulse_clr;
      @(posedge sys_clk) {window_a_flag_clr, window_b_flag_clr} <= 2'b11;
      @(posedge sys_clk) {window_a_flag_clr, window_b_flag_clr} <= 2'b00;
      tick(1);
   endtask : pulse_clr

   task automatic dac_req(input logic [7:0] c);
      @(posedge sys_clk) {dac_wr, dac_code} <= {1'b1, c};
      @(posedge sys_clk) dac_wr <= 1'b0;
      tick(3);
   endtask : dac_req

   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      print_verdict();
   end

   initial begin
      {srst, module_stop, elc_trig_enable, fire, dac_wr, samp_wr} = 6'h20;
      {group_a_chan8_select, group_b_chan8_select, chan8_add_avg_select,
       window_a_chan8_enable, window_a_chan8_condition, window_a_flag_clr,
       window_b_enable, window_b_condition, window_b_flag_clr,
       dac_sync_mode} = '0;
      scan_mode = MODE_SINGLE;
      res_in = '0;
      {group_a_select, group_b_select, add_avg_select} = '0;
      {window_a_level, window_b_level, window_b_channel_select} = '0;
      {rd_chan, samp_idx, samp_rd_idx, samp_data, dac_code} = '0;
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      tick(1);
      chk(samp_count_ff, `ADC_SAMP_RST, "samp reset");
      chk(rd_data_ff, 0, "result reset");
      chk({dac_adc_sync_enable_ff, analog_clk_enable}, 2'b11, "en");
      chk_ev(6'h00);
      scan_mode <= MODE_GROUP;
      {group_a_select, add_avg_select} <= {32'hFFFF_FF0F, 32'h0000_0F01};
      {group_a_chan8_select, chan8_add_avg_select} <= 2'b11;
      {elc_trig_enable, dac_sync_mode} <= 2'b11;
      trig(1);
      chk(scan_chan_mask_ff, 32'hFFFF_010F, "group A mask");
      chk(add_avg_mask_ff, 32'h0000_0101, "add mask");
      chk(dac_adc_sync_enable_ff, 0, "sync enable busy");
      dac_req(8'h5A);
      chk(dac_out, 8'h00, "dac held");
      trig(0);
      wr_res(6'h08, 12'hABC, 1'b0, 1'b0);
      chk_ev(6'h00);
      wr_res(6'h1F, 12'h123, 1'b1, 1'b0);
      chk_ev(6'h32);
      tick(1);
      chk_ev(6'h00);
      tick(2);
      chk(dac_out, 8'h5A, "dac released");
      {group_b_select, group_b_chan8_select} <= {32'h0000_FF30, 1'b1};
      wr_res(6'h05, 12'h001, 1'b1, 1'b1);
      chk_ev(6'h29);
      chk(scan_chan_mask_ff, 32'h0000_0130, "group B mask");
      scan_mode <= MODE_CONT;
      wr_res(6'h00, 12'h001, 1'b1, 1'b0);
      chk_ev(6'h22);
      rd(6'h08, 12'hABC);
      rd(6'h1F, 12'h123);
      rd(6'h09, 12'h000);
      samp(1'b1, 4'h8, 8'h55);
      samp(1'b1, 4'hB, 8'hAA);
      samp(1'b0, 4'h0, `ADC_SAMP_RST);
      scan_mode <= MODE_SINGLE;
      {window_a_chan8_enable, window_a_level} <= {1'b1, 12'h064};
      for (int i = 0; i < 4; i++) begin
         window_a_chan8_condition <= i[1];
         wr_res(6'h08, i[0] ? 12'h032 : 12'h0C8, 1'b0, 1'b0);
         chk_ev({3'b000, i[0] ^ i[1], 2'b00});
         chk(window_a_chan8_flag_ff, i[0] ^ i[1], "flag A");
         pulse_clr();
         chk(window_a_chan8_flag_ff, 0, "flag A clear");
      end
      window_a_chan8_enable <= 1'b0;
      {window_b_enable, window_b_condition} <= 2'b11;
      for (int i = 0; i < 10; i++) begin
         window_b_channel_select <= wb_code[i];
         tick(2);
         wr_res(wb_code[i], 12'hFFF, 1'b0, 1'b0);
         chk_ev({3'b000, i < 6, 2'b00});
         chk(window_b_flag_ff, i < 6, "flag B");
         pulse_clr();
      end
      scan_mode <= MODE_GROUP;
      module_stop <= 1'b1;
      tick(1);
      chk(analog_clk_enable, 0, "analog clock");
      wr_res(6'h00, 12'h001, 1'b1, 1'b0);
      chk_ev(6'h00);
      trig(0);
      module_stop <= 1'b0;
      tick(1);
      trig(1);
      dac_sync_mode <= 1'b0;
      tick(1);
      chk(dac_adc_sync_enable_ff, 1, "sync off");
      dac_req(8'hA5);
      chk(dac_out, 8'hA5, "dac free");
      print_verdict();
   end
endmodule : adc_scan_event_compare_select_tb

// file: verif/elc_dac_model.sv
// Purpose: Event link and D/A stand-in on the far side of the scan slice.
// Assumes: Every signal is on sys_clk.
// Notes:   A D/A update waits until the converter's enable allows it, or goes at once when sync mode is off.
`timescale 1ns/1ps
module elc_dac_model
   import adc_scan_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       fire,
   input  elc_event_t      events,
   input  wire logic       sync_en,
   input  wire logic       sync_mode,
   input  wire logic       dac_wr,
   input  wire logic [7:0] dac_code,
   output logic            trig_ff,
   output logic [7:0]      dac_out_ff,
   output logic [7:0]      event_cnt_ff
);
   logic       pend_ff;
   logic [7:0] code_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         trig_ff <= 1'b0;
         pend_ff <= 1'b0;
         code_ff <= 8'h00;
         dac_out_ff <= 8'h00;
         event_cnt_ff <= 8'h00;
      end else begin
         trig_ff <= fire & ~trig_ff;
         if (|events) begin
            event_cnt_ff <= event_cnt_ff + 8'h01;
         end
         if (dac_wr) begin
            pend_ff <= 1'b1;
            code_ff <= dac_code;
         end else if (pend_ff && (!sync_mode || sync_en)) begin
            dac_out_ff <= code_ff;
            pend_ff <= 1'b0;
         end
      end
   end
endmodule : elc_dac_model
